// ---- src/mcusc_top.sv ----
// System control of a small 4-bit microcontroller: interrupt sequencer,
// halt and wakeup, watchdog, data ROM access and detection level select.
// Assumes an APB master, a CPU core on pclk and a data ROM answering combinationally.
//
// Summary of operation
// - Level select resets to ones, maps thresholds.
// - Data ROM address built from five nibbles.
// - Data-low read returns ROM low nibble.
// - Data-high read returns ROM high nibble.
// - Data-high write clears enabled watchdog.
// - Interrupt enters 08H; reset 00H, wakeup 04H.
// - Interrupt source ticks at 32768 per second.
// - Enabled pending request accepted next clock.
// - Acceptance saves context, loads entry, one clock.
// - Entry clears the global interrupt enable.
// - Return restores context, sets enable.
// - No acceptance while enable is clear.
// - Halt stops clock, sets counter to 004.
// - Port A rising edge wakes from halt.
// - Wakeup waits 352us before running.
// - Reset wins in halt, enters 000.
// - Halt leaves stored data unchanged.
// - Watchdog times out after 0.128 second.
// - Watchdog cleared on wake, reset, halt, software.
// - Watchdog overflow resets the whole system.
`timescale 1ns/1ps
`default_nettype none

module mcusc_top
  import mcusc_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF,
  parameter int unsigned WDT_CYCLES = WDT_CYCLES_DEF,
  parameter int unsigned IRQ_CYCLES = IRQ_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PC_W-1:0] cpu_next_pc,
  input wire logic [PAGE_W-1:0] cpu_page,
  input wire logic [MEMPG_W-1:0] cpu_mempage,
  input wire logic cpu_carry,
  input wire logic cpu_zero,
  input wire logic halt_exec,
  input wire logic return_from_irq_exec,
  input wire logic [3:0] port_a_pins,
  input wire logic wdt_option,
  input wire logic [7:0] data_rom_rdata,
  output logic [19:0] data_rom_addr,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic cpu_run,
  output logic ctx_restore,
  output logic [PAGE_W-1:0] rs_page,
  output logic [MEMPG_W-1:0] rs_mempage,
  output logic rs_carry,
  output logic rs_zero,
  output logic wdt_reset,
  output logic pwm_output_enable,
  output logic [3:0] lvd_level,
  output logic [11:0] lvd_threshold_mv,
  output logic lvd_level_valid
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    mcusc_mode_t mode;
    logic [STAB_W-1:0] stab_cnt;
    logic [WDT_W-1:0] wdt_cnt;
    logic [IRQC_W-1:0] irq_cnt;
    logic [3:0] pa_meta;
    logic [3:0] pa_sync;
    logic [3:0] pa_prev;
    logic wdt_meta;
    logic wdt_en;
    logic irq_flag;
    logic irq_en;
    logic pwm_en;
    logic [3:0] lvd_sel;
    logic [11:0] lvd_mv;
    logic lvd_valid;
    logic [4:0][3:0] addr_nib;
    logic [PC_W-1:0] sv_pc;
    logic [PAGE_W-1:0] sv_page;
    logic [MEMPG_W-1:0] sv_mempage;
    logic sv_carry;
    logic sv_zero;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic cpu_run;
    logic restore;
    logic wdt_reset;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mcusc_st_t;

  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES - 1);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);
  localparam logic [IRQC_W-1:0] IRQ_LAST = IRQC_W'(IRQ_CYCLES - 1);

  localparam mcusc_st_t ST_RST = '{
    mode: MCUSC_STAB,
    lvd_sel: LVD_SEL_RST,
    lvd_mv: mcusc_lvd_mv(LVD_SEL_RST),
    lvd_valid: 1'b1,
    pc_load: 1'b1,
    pc_value: PC_RESET,
    default: '0
  };

  mcusc_st_t q, d;

  // Register index decode, shared by read and write.
  function automatic logic reg_hit(input logic [5:0] idx);
    reg_hit = (idx == IDX_STATUS) || (idx == IDX_PWM_CTRL) || (idx == IDX_LVD_SEL) ||
              (idx == IDX_DATA_LO) || (idx == IDX_DATA_HI);
    for (int i = 0; i < 5; i++) begin
      if (idx == IDX_ADDR[i]) begin
        reg_hit = 1'b1;
      end
    end
  endfunction

  // ****************************************************************
  // Next state.
  // ****************************************************************
  logic [5:0] idx;
  logic hit;
  logic wr_ok;
  logic wake_edge;
  logic irq_take;
  logic [3:0] rd_nib;

  assign idx = paddr[7:2];
  assign hit = reg_hit(idx) && (paddr[1:0] == 2'b00);
  assign wr_ok = psel && penable && q.pready && pwrite && hit;
  assign wake_edge = |(q.pa_sync & ~q.pa_prev);
  assign irq_take = (q.mode == MCUSC_RUN) && !halt_exec && !return_from_irq_exec && q.irq_en && q.irq_flag;

  always_comb begin
    rd_nib = 4'h0;
    if (idx == IDX_STATUS) begin
      rd_nib = {1'b0, q.irq_flag, cpu_carry, cpu_zero};
    end else if (idx == IDX_PWM_CTRL) begin
      rd_nib = {2'b00, q.irq_en, q.pwm_en};
    end else if (idx == IDX_LVD_SEL) begin
      rd_nib = q.lvd_sel;
    end else if (idx == IDX_DATA_LO) begin
      rd_nib = data_rom_rdata[3:0];
    end else if (idx == IDX_DATA_HI) begin
      rd_nib = data_rom_rdata[7:4];
    end
    for (int i = 0; i < 5; i++) begin
      if (idx == IDX_ADDR[i]) begin
        rd_nib = q.addr_nib[i];
      end
    end
  end

  always_comb begin
    d = q;
    d.pc_load = 1'b0;
    d.restore = 1'b0;
    d.wdt_reset = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.pa_meta = port_a_pins;
    d.pa_sync = q.pa_meta;
    d.pa_prev = q.pa_sync;
    d.wdt_meta = wdt_option;
    d.wdt_en = q.wdt_meta;

    // APB: one wait cycle, then the write lands where pready is sampled.
    if (psel && penable && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !hit;
      d.prdata = {28'h0000000, rd_nib};
    end

    // Watchdog counts while the core clock runs.
    if (q.wdt_en && (q.mode != MCUSC_HALT)) begin
      d.wdt_cnt = q.wdt_cnt + WDT_W'(1);
    end

    if (wr_ok) begin
      if (idx == IDX_STATUS && !pwdata[BIT_IRQ_FLAG]) begin
        d.irq_flag = 1'b0;
      end
      if (idx == IDX_PWM_CTRL) begin
        d.irq_en = pwdata[BIT_IRQ_EN];
        d.pwm_en = pwdata[BIT_PWM_EN];
      end
      if (idx == IDX_LVD_SEL) begin
        d.lvd_sel = pwdata[3:0];
      end
      if (idx == IDX_DATA_HI && q.wdt_en) begin
        d.wdt_cnt = '0;
      end
      for (int i = 0; i < 5; i++) begin
        if (idx == IDX_ADDR[i]) begin
          d.addr_nib[i] = pwdata[3:0];
        end
      end
    end
    d.lvd_mv = mcusc_lvd_mv(d.lvd_sel);
    d.lvd_valid = !(d.lvd_sel inside {4'h5, 4'h6, 4'h7});

    // Request source ticks only while the core runs; the set wins over a clear.
    if (q.mode == MCUSC_RUN) begin
      if (q.irq_cnt == IRQ_LAST) begin
        d.irq_cnt = '0;
        if (q.pwm_en) begin
          d.irq_flag = 1'b1;
        end
      end else begin
        d.irq_cnt = q.irq_cnt + IRQC_W'(1);
      end
    end

    unique case (q.mode)
      MCUSC_RUN: begin
        if (halt_exec) begin
          d.mode = MCUSC_HALT;
          d.pc_load = 1'b1;
          d.pc_value = PC_WAKE;
          d.cpu_run = 1'b0;
          d.pwm_en = 1'b0;
          d.wdt_cnt = '0;
        end else if (return_from_irq_exec) begin
          d.restore = 1'b1;
          d.pc_load = 1'b1;
          d.pc_value = q.sv_pc;
          d.irq_en = 1'b1;
        end else if (irq_take) begin
          d.sv_pc = cpu_next_pc;
          d.sv_page = cpu_page;
          d.sv_mempage = cpu_mempage;
          d.sv_carry = cpu_carry;
          d.sv_zero = cpu_zero;
          d.pc_load = 1'b1;
          d.pc_value = PC_IRQ;
          d.irq_en = 1'b0;
        end
      end
      MCUSC_HALT: begin
        // Stored registers are left alone here.
        if (wake_edge) begin
          d.mode = MCUSC_STAB;
          d.stab_cnt = '0;
          d.wdt_cnt = '0;
        end
      end
      MCUSC_STAB: begin
        if (q.stab_cnt == STAB_LAST) begin
          d.mode = MCUSC_RUN;
          d.cpu_run = 1'b1;
          d.stab_cnt = '0;
        end else begin
          d.stab_cnt = q.stab_cnt + STAB_W'(1);
        end
      end
      default: begin
        d.mode = MCUSC_STAB;
        d.stab_cnt = '0;
      end
    endcase

    // Overflow reinitialises the system and restarts from the reset entry.
    if (q.wdt_en && (q.mode != MCUSC_HALT) && (q.wdt_cnt == WDT_LAST)) begin
      d = ST_RST;
      d.wdt_reset = 1'b1;
      d.pc_value = PC_RESET;
      d.pa_meta = port_a_pins;
      d.pa_sync = q.pa_meta;
      d.pa_prev = q.pa_sync;
      d.wdt_meta = wdt_option;
      d.wdt_en = q.wdt_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign data_rom_addr = {q.addr_nib[4], q.addr_nib[3], q.addr_nib[2], q.addr_nib[1], q.addr_nib[0]};
  assign pc_load = q.pc_load;
  assign pc_value = q.pc_value;
  assign cpu_run = q.cpu_run;
  assign ctx_restore = q.restore;
  assign rs_page = q.sv_page;
  assign rs_mempage = q.sv_mempage;
  assign rs_carry = q.sv_carry;
  assign rs_zero = q.sv_zero;
  assign wdt_reset = q.wdt_reset;
  assign pwm_output_enable = q.pwm_en;
  assign lvd_level = q.lvd_sel;
  assign lvd_threshold_mv = q.lvd_mv;
  assign lvd_level_valid = q.lvd_valid;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // An interrupt is qualified only where no overflow preempts it.
  // The entry step shows the entry address and a cleared enable.

  sequence irq_cond_s;
    irq_take && !q.wdt_reset && !(q.wdt_en && q.wdt_cnt == WDT_LAST);
  endsequence

  sequence irq_entry_s;
    pc_load && (pc_value == PC_IRQ) && !q.irq_en;
  endsequence

  irq_entry_a: assert property (irq_cond_s |=> irq_entry_s)
    else $error("interrupt not entered on the next clock");
  irq_context_a: assert property (irq_cond_s |=> (q.sv_pc == $past(cpu_next_pc)) && (rs_carry == $past(cpu_carry)))
    else $error("interrupt context not saved");
  irq_masked_a: assert property (!q.irq_en |=> !(pc_load && pc_value == PC_IRQ))
    else $error("interrupt taken while disabled");
  // A software clear in the acceptance cycle or the cycle after it is legal, so both are left out.
  irq_flag_kept_a: assert property ((irq_cond_s ##0 !wr_ok) ##1 !wr_ok |=> q.irq_flag)
    else $error("request flag cleared by hardware");
  return_from_irq_restore_a: assert property ((q.mode == MCUSC_RUN) && return_from_irq_exec && !halt_exec && !q.wdt_reset
      && !(q.wdt_en && q.wdt_cnt == WDT_LAST) |=> ctx_restore && q.irq_en && (pc_value == $past(q.sv_pc)))
    else $error("return did not restore context");
  halt_entry_a: assert property ((q.mode == MCUSC_RUN) && halt_exec && !(q.wdt_en && q.wdt_cnt == WDT_LAST)
      |=> (q.mode == MCUSC_HALT) && (pc_value == PC_WAKE) && !cpu_run && (q.wdt_cnt == '0))
    else $error("halt entry wrong");
  wake_start_a: assert property ((q.mode == MCUSC_HALT) && wake_edge |=> (q.mode == MCUSC_STAB) && !cpu_run ##1 !cpu_run)
    else $error("wakeup did not start stabilisation");
  stab_hold_a: assert property ((q.mode == MCUSC_STAB) && (q.stab_cnt != STAB_LAST) |=> !cpu_run)
    else $error("core ran before stabilisation ended");
  wdt_clear_a: assert property (wr_ok && (idx == IDX_DATA_HI) && q.wdt_en && !(q.wdt_cnt == WDT_LAST) |=> q.wdt_cnt == '0)
    else $error("watchdog not cleared by data-high write");
  wdt_over_a: assert property (q.wdt_en && (q.mode != MCUSC_HALT) && (q.wdt_cnt == WDT_LAST)
      |=> wdt_reset && (q.mode == MCUSC_STAB) && (pc_value == PC_RESET) && !q.irq_en)
    else $error("watchdog overflow did not reset");
  data_low_a: assert property (psel && penable && !q.pready && !pwrite && (paddr == {IDX_DATA_LO, 2'b00})
      |=> pready && (prdata[3:0] == $past(data_rom_rdata[3:0])))
    else $error("data-low read wrong");

  // Stored address nibbles stay put while the core clock is stopped.
  halt_kept_a: assert property ((q.mode == MCUSC_HALT) && !wr_ok |=> $stable(data_rom_addr))
    else $error("stored data changed during halt");

endmodule

`default_nettype wire

// ---- src/mcusc_pkg.sv ----
// Constants, register map and types of the system control block.
// Assumes a 200 MHz pclk and an APB master on the register port.
package mcusc_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned STAB_TIME_US = 352;
  localparam int unsigned STAB_CYCLES_DEF = (STAB_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDT_TIME_MS = 128;
  localparam int unsigned WDT_CYCLES_DEF = (WDT_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_RATE_HZ = 32768;
  localparam int unsigned IRQ_CYCLES_DEF = CLK_HZ / IRQ_RATE_HZ;

  // ****************************************************************
  // Widths.
  // ****************************************************************
  localparam int PC_W = 13;
  localparam int PAGE_W = 4;
  localparam int MEMPG_W = 2;
  localparam int STAB_W = 17;
  localparam int WDT_W = 25;
  localparam int IRQC_W = 13;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_PWM_CTRL = 6'h09;
  localparam logic [5:0] IDX_LVD_SEL = 6'h14;
  localparam logic [4:0][5:0] IDX_ADDR = {6'h1e, 6'h1b, 6'h1a, 6'h19, 6'h18};
  localparam logic [5:0] IDX_DATA_LO = 6'h1c;
  localparam logic [5:0] IDX_DATA_HI = 6'h1d;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int BIT_ZERO = 0;
  localparam int BIT_CARRY = 1;
  localparam int BIT_IRQ_FLAG = 2;
  localparam int BIT_PWM_EN = 0;
  localparam int BIT_IRQ_EN = 1;
  localparam logic [3:0] LVD_SEL_RST = 4'hf;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_WAKE = 13'h0004;
  localparam logic [PC_W-1:0] PC_IRQ = 13'h0008;

  typedef enum logic [1:0] {
    MCUSC_RUN = 2'b00,
    MCUSC_HALT = 2'b01,
    MCUSC_STAB = 2'b10
  } mcusc_mode_t;

  // Detection threshold in millivolts; zero for the undefined codes.
  function automatic logic [11:0] mcusc_lvd_mv(input logic [3:0] code);
    unique case (code)
      4'h8: mcusc_lvd_mv = 12'h640;
      4'h9: mcusc_lvd_mv = 12'h6a4;
      4'ha: mcusc_lvd_mv = 12'h708;
      4'hb: mcusc_lvd_mv = 12'h7d0;
      4'hc: mcusc_lvd_mv = 12'h898;
      4'hd: mcusc_lvd_mv = 12'h960;
      4'he: mcusc_lvd_mv = 12'ha8c;
      4'hf: mcusc_lvd_mv = 12'haf0;
      4'h0: mcusc_lvd_mv = 12'hbb8;
      4'h1: mcusc_lvd_mv = 12'hce4;
      4'h2: mcusc_lvd_mv = 12'he10;
      4'h3: mcusc_lvd_mv = 12'he74;
      4'h4: mcusc_lvd_mv = 12'hed8;
      default: mcusc_lvd_mv = 12'h000;
    endcase
  endfunction

endpackage

// ---- bench/mcusc_core_model.sv ----
// CPU core model: program counter and the context it hands over.
// Assumes pc_load, pc_value and cpu_run from the system control block.
`timescale 1ns/1ps
`default_nettype none

module mcusc_core_model
  import mcusc_pkg::*;
(
  input wire logic pclk,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic cpu_run,
  output logic [PC_W-1:0] cpu_next_pc,
  output logic [PAGE_W-1:0] cpu_page,
  output logic [MEMPG_W-1:0] cpu_mempage,
  output logic cpu_carry,
  output logic cpu_zero
);
  logic [PC_W-1:0] pc_q = '0;

  // Loads the given address, else steps only while its clock runs.
  always @(posedge pclk) begin
    if (pc_load)
      pc_q <= pc_value;
    else if (cpu_run)
      pc_q <= pc_q + 13'h1;
  end

  // Context changes every step so a stale save shows up.
  assign cpu_next_pc = pc_q + 13'h1;
  assign cpu_page = pc_q[3:0] ^ pc_q[7:4];
  assign cpu_mempage = pc_q[1:0];
  assign cpu_carry = pc_q[0];
  assign cpu_zero = ~pc_q[1];
endmodule

`default_nettype wire

// ---- bench/mcu_system_control_test.sv ----
// Self-checking bench of the system control block.
// Assumes the core model and a combinational data ROM held by the bench.
`timescale 1ns/1ps
`default_nettype none

module mcu_system_control_test;
  import mcusc_pkg::*;
  localparam int STAB = 8;
  localparam int WDT = 64;
  localparam logic [7:0] A_LVD = {IDX_LVD_SEL, 2'b00};
  localparam logic [7:0] A_CTL = {IDX_PWM_CTRL, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_DLO = {IDX_DATA_LO, 2'b00};
  localparam logic [7:0] A_DHI = {IDX_DATA_HI, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic halt_exec = 0, return_from_irq_exec = 0, wdt_option = 0, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, seed = 32'h51ded78a;
  logic [3:0] port_a_pins = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pc_load, cpu_run, ctx_restore, rs_carry, rs_zero;
  logic wdt_reset, pwm_output_enable, lvd_level_valid, cpu_carry, cpu_zero;
  logic [7:0] data_rom_rdata;
  logic [19:0] data_rom_addr, addr_m = '0;
  logic [PC_W-1:0] pc_value, cpu_next_pc;
  logic [PAGE_W-1:0] rs_page, cpu_page;
  logic [MEMPG_W-1:0] rs_mempage, cpu_mempage;
  logic [3:0] lvd_level;
  logic [11:0] lvd_threshold_mv;
  logic [20:0] p_ctx, sv_ctx;
  int err_total = 0, n_tests = 0, wdt_seen = 0, n, n_wait;
  int mv_tab[16] = '{3000, 3300, 3600, 3700, 3800, 0, 0, 0, 1600, 1700, 1800, 2000, 2200, 2400, 2700, 2800};

  mcusc_top #(.STAB_CYCLES(STAB), .WDT_CYCLES(WDT), .IRQ_CYCLES(16)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_next_pc(cpu_next_pc), .cpu_page(cpu_page), .cpu_mempage(cpu_mempage),
    .cpu_carry(cpu_carry), .cpu_zero(cpu_zero), .halt_exec(halt_exec), .return_from_irq_exec(return_from_irq_exec),
    .port_a_pins(port_a_pins), .wdt_option(wdt_option), .data_rom_rdata(data_rom_rdata),
    .data_rom_addr(data_rom_addr), .pc_load(pc_load), .pc_value(pc_value), .cpu_run(cpu_run),
    .ctx_restore(ctx_restore), .rs_page(rs_page), .rs_mempage(rs_mempage), .rs_carry(rs_carry),
    .rs_zero(rs_zero), .wdt_reset(wdt_reset), .pwm_output_enable(pwm_output_enable),
    .lvd_level(lvd_level), .lvd_threshold_mv(lvd_threshold_mv), .lvd_level_valid(lvd_level_valid)
  );

  mcusc_core_model core (
    .pclk(pclk), .pc_load(pc_load), .pc_value(pc_value), .cpu_run(cpu_run),
    .cpu_next_pc(cpu_next_pc), .cpu_page(cpu_page), .cpu_mempage(cpu_mempage),
    .cpu_carry(cpu_carry), .cpu_zero(cpu_zero)
  );

  // ****************************************************************
  // Clock, data ROM and monitors.
  // ****************************************************************
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [7:0] rom(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], a[19:16]};
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  assign data_rom_rdata = rom(data_rom_addr);

  // Keeps the core context of the previous edge and counts watchdog pulses.
  always @(posedge pclk) begin
    p_ctx <= {cpu_next_pc, cpu_page, cpu_mempage, cpu_carry, cpu_zero};
    if (wdt_reset === 1'b1)
      wdt_seen++;
  end

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {28'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wait_cnt(input logic which);
    n_wait = 0;
    while ((which ? cpu_run : pc_load) !== 1'b1 && n_wait < 200) begin
      @(posedge pclk);
      n_wait++;
    end
  endtask

  task automatic rst();
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    addr_m = '0;
    wait_cnt(1);
  endtask

  task automatic core_op(input logic h);
    if (h)
      halt_exec <= 1;
    else
      return_from_irq_exec <= 1;
    @(posedge pclk);
    halt_exec <= 0;
    return_from_irq_exec <= 0;
    wait_cnt(0);
  endtask

  task automatic entry();
    sv_ctx = p_ctx;
    chk("irq pc", PC_IRQ, pc_value);
    chk("saved ctx", p_ctx[7:0], {rs_page, rs_mempage, rs_carry, rs_zero});
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    test_done();
  end

  // ****************************************************************
  // Tests.
  // ****************************************************************
  initial begin
    rst();
    chk("lvd reset", 4'hf, lvd_level);
    apb(0, A_LVD, 0);
    chk("lvd reg reset", 4'hf, rd);
    for (int i = 0; i < 16; i++) begin
      apb(1, A_LVD, i[3:0]);
      apb(0, A_LVD, 0);
      chk("lvd reg", i, rd);
      chk("lvd mv", mv_tab[i], lvd_threshold_mv);
      chk("lvd valid", mv_tab[i] != 0, lvd_level_valid);
    end
    $display("test level select done");
    repeat (3) begin
      for (int i = 0; i < 5; i++) begin
        seed = xs(seed);
        apb(1, {IDX_ADDR[i], 2'b00}, seed[3:0]);
        addr_m[4*i +: 4] = seed[3:0];
      end
      chk("data_rom_addr", addr_m, data_rom_addr);
      apb(0, A_DLO, 0);
      chk("data low", rom(addr_m) & 8'h0f, rd);
      apb(0, A_DHI, 0);
      chk("data high", rom(addr_m) >> 4, rd);
    end
    apb(0, 8'h54, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    $display("test data rom done");
    apb(1, A_CTL, 4'h3);
    wait_cnt(0);
    entry();
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      n += pc_load;
    end
    chk("nested entries", 0, n);
    apb(0, A_CTL, 0);
    chk("enable cleared", 4'h1, rd);
    apb(0, A_ST, 0);
    chk("flag kept", 1, rd[2]);
    apb(1, A_CTL, 4'h2);
    wait_cnt(0);
    chk("accept delay", 1, n_wait);
    entry();
    apb(1, A_CTL, 4'h0);
    apb(1, A_ST, 4'h0);
    core_op(0);
    chk("return pc", sv_ctx[20:8], pc_value);
    chk("ctx restore", 1, ctx_restore);
    apb(0, A_CTL, 0);
    chk("enable set", 4'h2, rd);
    $display("test interrupt done");
    apb(1, A_CTL, 4'h1);
    core_op(1);
    chk("halt pc", PC_WAKE, pc_value);
    chk("halt run", 0, cpu_run);
    n = 0;
    repeat (100) begin
      @(posedge pclk);
      n += cpu_run;
    end
    chk("halted runs", 0, n);
    chk("pwm cleared", 0, pwm_output_enable);
    port_a_pins <= 4'h4;
    wait_cnt(1);
    chk("wake delay", 1, n_wait >= STAB && n_wait <= STAB + 6);
    chk("addr kept", addr_m, data_rom_addr);
    port_a_pins <= 4'h0;
    core_op(1);
    rst();
    chk("reset pc", PC_RESET, pc_value);
    chk("reset delay", 1, n_wait >= STAB - 1 && n_wait <= STAB + 3);
    $display("test halt done");
    wdt_option <= 1;
    rst();
    apb(1, A_LVD, 4'h3);
    wdt_seen = 0;
    repeat (6) begin
      repeat (40) @(posedge pclk);
      apb(1, A_DHI, 4'h0);
    end
    chk("wdt quiet", 0, wdt_seen);
    n = 0;
    while (wdt_reset !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("wdt period", 1, n >= WDT - 4 && n <= WDT + 3);
    repeat (2) @(posedge pclk);
    chk("wdt reinit lvd", 4'hf, lvd_level);
    chk("wdt reinit pc", PC_RESET, pc_value);
    wdt_option <= 0;
    $display("test watchdog done");
    test_done();
  end
endmodule

`default_nettype wire
